/* File: rtl/power_reset_pkg.sv */
package power_reset_pkg;

  // ****************************************
  // Power states
  // ****************************************
  typedef enum logic [2:0] {
    PWR_ACTIVE  = 3'b001,
    PWR_STANDBY = 3'b010,
    PWR_SLEEP   = 3'b100
  } pwr_state_t;

  // ****************************************
  // Counts, widths and reset values
  // ****************************************
  localparam int          PD_COUNT_DEFAULT    = 256;
  localparam int          PD_CNT_W            = 16;
  localparam int          IDLE_COUNT_DEFAULT  = 4;
  localparam int          IDLE_CNT_W          = 4;
  localparam int          LOGIC_IN_W_DEFAULT  = 8;
  localparam int          BLOCK_W_DEFAULT     = 4;
  localparam logic [0:0]  RESET_OUT_ACTIVE    = 1'h0;
  localparam logic [15:0] PD_CNT_RESET        = 16'h0000;
  localparam logic [3:0]  IDLE_CNT_RESET      = 4'h0;

endpackage : power_reset_pkg

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int          W        = 1,
  parameter logic [31:0] RST_VAL  = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two stages; the first is read only by the second
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q   <= RST_VAL[W-1:0];
      sync_out <= RST_VAL[W-1:0];
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

/* File: rtl/power_and_reset_control.sv */
// Behaviour
// - With the logic standby bit set, both logic arrays drop to standby while none of their inputs change.
// - The auto power-down unit puts the device in standby or sleep when the address latch strobe is idle.
// - Which strobe level counts as idle is chosen by a user polarity input.
// - A sleep mode, lower power than standby, exists and may be chosen as the auto power-down target.
// - Chip select is active low and while it is high the device stays in standby.
// - A low reset input resets ports, macrocells and configuration registers.
// - A reset output for the host is derived from the reset input.
// - The logic clock input clocks the macrocells, the logic arrays and the auto power-down counter.
// - The power manager lets the user gate power per functional block.
`timescale 1ns/1ns
module power_and_reset_control #(
  parameter int PD_COUNT   = power_reset_pkg::PD_COUNT_DEFAULT,
  parameter int IDLE_COUNT = power_reset_pkg::IDLE_COUNT_DEFAULT,
  parameter int LOGIC_IN_W = power_reset_pkg::LOGIC_IN_W_DEFAULT,
  parameter int BLOCK_W    = power_reset_pkg::BLOCK_W_DEFAULT
) (
  // Clock, enable and reset
  input  wire logic                  mclk,
  input  wire logic                  clk_en,
  input  wire logic                  resetn,
  // Host pins
  input  wire logic                  chip_select_n,
  input  wire logic                  addr_latch_strobe,
  input  wire logic                  reset_in_n,
  input  wire logic [LOGIC_IN_W-1:0] logic_array_in,
  // Configuration
  input  wire logic                  logic_standby_en,
  input  wire logic                  auto_power_down_en,
  input  wire logic                  strobe_idle_level,
  input  wire logic                  auto_power_down_sleep,
  input  wire logic                  reset_out_en,
  input  wire logic [BLOCK_W-1:0]    block_power_off,
  // Status and controls out
  output logic [2:0]                 power_state,
  output logic                       device_standby,
  output logic                       device_sleep,
  output logic                       decode_logic_array_standby,
  output logic                       general_logic_array_standby,
  output logic                       logic_array_clk_en,
  output logic [BLOCK_W-1:0]         block_power_en,
  output logic                       config_reset_n,
  output logic                       reset_out_n
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial begin
    if (PD_COUNT < 1 || PD_COUNT >= (1 << power_reset_pkg::PD_CNT_W))
      $error("Power-down count out of range");
    if (IDLE_COUNT < 1 || IDLE_COUNT >= (1 << power_reset_pkg::IDLE_CNT_W))
      $error("IDLE_COUNT out of range");
    if (LOGIC_IN_W < 1 || BLOCK_W < 1)
      $error("Widths must be positive");
    // Synchroniser reset word is 32 bits wide
    if (LOGIC_IN_W > 29)
      $error("Too many logic inputs for the synchroniser");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = LOGIC_IN_W + 3;

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_sync;

  assign pins_raw = {logic_array_in, reset_in_n, addr_latch_strobe, chip_select_n};

  // Selects and reset start inactive so the device sits in standby out of reset
  pin_sync #(
    .W       (SW),
    .RST_VAL (32'h0000_0005)
  ) u_pin_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  wire                  cs_n_s   = pins_sync[0];
  wire                  ale_s    = pins_sync[1];
  wire                  rst_in_s = pins_sync[2];
  wire [LOGIC_IN_W-1:0] lin_s    = pins_sync[SW-1:3];

  // ****************************************
  // Reset distribution
  // ****************************************
  logic rst_in_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rst_in_q <= 1'b0;
    end else if (clk_en) begin
      rst_in_q <= rst_in_s;
    end
  end

  // Both the system reset and the host reset pin clear configuration
  wire int_rst_n = resetn && rst_in_q;

  logic reset_out_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reset_out_q <= power_reset_pkg::RESET_OUT_ACTIVE;
    end else if (clk_en) begin
      reset_out_q <= rst_in_q;
    end
  end

  // ****************************************
  // Strobe activity and auto power-down
  // ****************************************
  logic                                ale_q;
  logic [power_reset_pkg::PD_CNT_W-1:0] pd_cnt_q;
  logic [power_reset_pkg::PD_CNT_W-1:0] pd_cnt_d;
  logic                                pd_down_q;

  localparam logic [power_reset_pkg::PD_CNT_W-1:0] PD_TERM =
    power_reset_pkg::PD_CNT_W'(PD_COUNT);

  wire ale_toggle = ale_s != ale_q;
  wire ale_idle   = (ale_s == strobe_idle_level) && !ale_toggle;
  wire pd_term    = pd_cnt_q == PD_TERM;

  // Saturate at terminal count so the power-down holds
  assign pd_cnt_d = (!auto_power_down_en || !ale_idle) ? power_reset_pkg::PD_CNT_RESET :
                    pd_term ? pd_cnt_q : pd_cnt_q + 1'b1;

  always_ff @(posedge mclk) begin
    if (!int_rst_n) begin
      ale_q     <= 1'b0;
      pd_cnt_q  <= power_reset_pkg::PD_CNT_RESET;
      pd_down_q <= 1'b0;
    end else if (clk_en) begin
      ale_q     <= ale_s;
      pd_cnt_q  <= pd_cnt_d;
      pd_down_q <= auto_power_down_en && ale_idle && (pd_term || pd_cnt_d == PD_TERM);
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  power_reset_pkg::pwr_state_t state_q;
  power_reset_pkg::pwr_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      power_reset_pkg::PWR_ACTIVE: begin
        if (cs_n_s)
          state_d = power_reset_pkg::PWR_STANDBY;
        else if (pd_down_q)
          state_d = auto_power_down_sleep ? power_reset_pkg::PWR_SLEEP : power_reset_pkg::PWR_STANDBY;
      end
      power_reset_pkg::PWR_STANDBY: begin
        if (!cs_n_s && !pd_down_q)
          state_d = power_reset_pkg::PWR_ACTIVE;
        else if (!cs_n_s && pd_down_q && auto_power_down_sleep)
          state_d = power_reset_pkg::PWR_SLEEP;
      end
      power_reset_pkg::PWR_SLEEP: begin
        // Strobe activity or auto_power_down_en low wakes from sleep; chip select high falls back to standby
        if (cs_n_s)
          state_d = power_reset_pkg::PWR_STANDBY;
        else if (!pd_down_q)
          state_d = power_reset_pkg::PWR_ACTIVE;
      end
      default: state_d = power_reset_pkg::PWR_STANDBY;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!int_rst_n) begin
      state_q <= power_reset_pkg::PWR_STANDBY;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Logic array input-idle standby
  // ****************************************
  logic [LOGIC_IN_W-1:0]                  lin_q;
  logic [power_reset_pkg::IDLE_CNT_W-1:0] idle_cnt_q;
  logic                                   arrays_idle_q;
  logic                                   cs_q;

  localparam logic [power_reset_pkg::IDLE_CNT_W-1:0] IDLE_TERM =
    power_reset_pkg::IDLE_CNT_W'(IDLE_COUNT);

  // Strobe and select are array inputs too, so any edge on them wakes the arrays
  wire inputs_moving = (lin_s != lin_q) || ale_toggle || (cs_n_s != cs_q);

  always_ff @(posedge mclk) begin
    if (!int_rst_n) begin
      lin_q         <= '0;
      cs_q          <= 1'b1;
      idle_cnt_q    <= power_reset_pkg::IDLE_CNT_RESET;
      arrays_idle_q <= 1'b0;
    end else if (clk_en) begin
      lin_q <= lin_s;
      cs_q  <= cs_n_s;
      if (inputs_moving || !logic_standby_en) begin
        idle_cnt_q    <= power_reset_pkg::IDLE_CNT_RESET;
        arrays_idle_q <= 1'b0;
      end else if (idle_cnt_q != IDLE_TERM) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end else begin
        arrays_idle_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic             dev_standby_q;
  logic             dev_sleep_q;
  logic             dpla_sb_q;
  logic             gpla_sb_q;
  logic             la_clk_en_q;
  logic [BLOCK_W-1:0] blk_en_q;

  wire powered_down = state_q != power_reset_pkg::PWR_ACTIVE;

  always_ff @(posedge mclk) begin
    if (!int_rst_n) begin
      dev_standby_q <= 1'b1;
      dev_sleep_q   <= 1'b0;
      dpla_sb_q     <= 1'b1;
      gpla_sb_q     <= 1'b1;
      la_clk_en_q   <= 1'b0;
      blk_en_q      <= '0;
    end else if (clk_en) begin
      dev_standby_q <= state_d == power_reset_pkg::PWR_STANDBY;
      dev_sleep_q   <= state_d == power_reset_pkg::PWR_SLEEP;
      dpla_sb_q     <= powered_down || arrays_idle_q;
      gpla_sb_q     <= powered_down || arrays_idle_q;
      la_clk_en_q   <= state_d != power_reset_pkg::PWR_SLEEP;
      blk_en_q      <= powered_down ? '0 : ~block_power_off;
    end
  end

  assign power_state                 = state_q;
  assign device_standby              = dev_standby_q;
  assign device_sleep                = dev_sleep_q;
  assign decode_logic_array_standby  = dpla_sb_q;
  assign general_logic_array_standby = gpla_sb_q;
  assign logic_array_clk_en          = la_clk_en_q;
  assign block_power_en              = blk_en_q;
  assign config_reset_n              = int_rst_n;
  assign reset_out_n                 = reset_out_en ? reset_out_q : 1'b1;

endmodule : power_and_reset_control

/* File: tb/host_model.sv */
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic mclk,
  // Host pins
  output logic      chip_select_n,
  output logic      addr_latch_strobe,
  output logic      reset_in_n
);
  // ****
  // Pin driver
  // ****
  initial begin
    chip_select_n = 1'h1;
    addr_latch_strobe = 1'h0;
    reset_in_n = 1'h1;
  end
  // Levels only: the host never glitches a pin mid-cycle
  task automatic pins(input logic cs_n, input logic ale, input logic rst_n);
    @(negedge mclk);
    chip_select_n <= cs_n;
    addr_latch_strobe <= ale;
    reset_in_n <= rst_n;
  endtask : pins
endmodule : host_model

/* File: tb/power_and_reset_control_sva.sv */
`timescale 1ns/1ns
module power_and_reset_control_sva #(
  parameter int BLOCK_W = 4
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic               clk_en,
  // Watched ports
  input wire logic               chip_select_n,
  input wire logic               reset_in_n,
  input wire logic               reset_out_en,
  input wire logic [2:0]         power_state,
  input wire logic               device_standby,
  input wire logic               device_sleep,
  input wire logic               decode_logic_array_standby,
  input wire logic               general_logic_array_standby,
  input wire logic               logic_array_clk_en,
  input wire logic [BLOCK_W-1:0] block_power_en,
  input wire logic               config_reset_n,
  input wire logic               reset_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_state_onehot: assert property ($onehot(power_state)) else $error("state not one-hot");
  a_standby_flag: assert property (device_standby == (power_state == power_reset_pkg::PWR_STANDBY))
    else $error("standby flag disagrees");
  a_sleep_clk: assert property (device_sleep |-> !logic_array_clk_en && power_state == power_reset_pkg::PWR_SLEEP)
    else $error("sleep without clock stop");
  a_arrays_pair: assert property (decode_logic_array_standby == general_logic_array_standby)
    else $error("arrays disagree");
  a_down_arrays: assert property (clk_en && power_state != power_reset_pkg::PWR_ACTIVE |=>
    decode_logic_array_standby && general_logic_array_standby) else $error("arrays awake while down");
  a_cs_standby: assert property ((clk_en && chip_select_n) [*4] |=> device_standby)
    else $error("deselected but awake");
  a_block_gate: assert property (clk_en && power_state != power_reset_pkg::PWR_ACTIVE ##1
    power_state != power_reset_pkg::PWR_ACTIVE |-> ~|block_power_en) else $error("block powered off-state");
  a_pin_reset: assert property ((clk_en && !reset_in_n) [*5] |=> !config_reset_n && device_standby)
    else $error("reset pin ignored");
  a_rstout_off: assert property (!reset_out_en |-> reset_out_n) else $error("reset out driven");
endmodule : power_and_reset_control_sva

bind power_and_reset_control power_and_reset_control_sva #(.BLOCK_W(BLOCK_W)) u_sva (
  .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .chip_select_n(chip_select_n), .reset_in_n(reset_in_n),
  .reset_out_en(reset_out_en), .power_state(power_state), .device_standby(device_standby),
  .device_sleep(device_sleep), .decode_logic_array_standby(decode_logic_array_standby),
  .general_logic_array_standby(general_logic_array_standby), .logic_array_clk_en(logic_array_clk_en),
  .block_power_en(block_power_en), .config_reset_n(config_reset_n), .reset_out_n(reset_out_n));

/* File: tb/power_and_reset_control_tb.sv */
`timescale 1ns/1ns
module power_and_reset_control_tb;
  // ****
  // Bench
  // ****
  localparam int PD_N = 8;
  logic mclk = 1'h0, resetn = 1'h0, clk_en = 1'h1, ls_en = 1'h0, pd_en = 1'h0, idle_lvl = 1'h0;
  logic sleep_sel = 1'h0, rst_out_en = 1'h1, cs_n, ale, rst_n, dl_sb, gl_sb, clk_out, cfg_rst_n, rst_out_n;
  logic dev_sb, dev_sl;
  logic [7:0] arr_in = 8'h00;
  logic [3:0] blk_off = 4'h0, blk_en;
  logic [2:0] state;
  logic [15:0] rnd = 16'h999D;
  int bad_count = 0, n_tests = 0, cycles = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  host_model HOST (.mclk(mclk), .chip_select_n(cs_n), .addr_latch_strobe(ale), .reset_in_n(rst_n));
  power_and_reset_control #(.PD_COUNT(PD_N)) DUT (
    .mclk(mclk), .clk_en(clk_en), .resetn(resetn), .chip_select_n(cs_n), .addr_latch_strobe(ale),
    .reset_in_n(rst_n), .logic_array_in(arr_in), .logic_standby_en(ls_en), .auto_power_down_en(pd_en),
    .strobe_idle_level(idle_lvl), .auto_power_down_sleep(sleep_sel), .reset_out_en(rst_out_en),
    .block_power_off(blk_off), .power_state(state), .device_standby(dev_sb), .device_sleep(dev_sl),
    .decode_logic_array_standby(dl_sb), .general_logic_array_standby(gl_sb), .logic_array_clk_en(clk_out),
    .block_power_en(blk_en), .config_reset_n(cfg_rst_n), .reset_out_n(rst_out_n));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Expected one-hot state: deselect wins over the idle timer
  function automatic int model(input int desel, input int idle, input int sel);
    return desel ? 2 : (idle ? (sel ? 4 : 2) : 1);
  endfunction : model
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    step(6);
    check(state, 8'h02);
    check(cfg_rst_n, 8'h00);
    check(rst_out_n, 8'h00);
    resetn <= 1'h1;
    clk_en <= 1'h0;
    HOST.pins(1'h0, 1'h0, 1'h1);
    step(8);
    check(state, 8'h02);
    clk_en <= 1'h1;
    step(6);
    check(state, model(0, 0, 0));
    check(rst_out_n, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      blk_off <= rnd[3:0];
      step(3);
      check(blk_en, {4'h0, ~blk_off});
    end
    HOST.pins(1'h1, 1'h0, 1'h1);
    step(6);
    check(state, model(1, 0, 0));
    check(blk_en, 8'h00);
    check(dev_sb, 8'h01);
    HOST.pins(1'h0, 1'h0, 1'h1);
    // Both polarities, both targets; non-idle hold must never time out
    for (int s = 0; s < 2; s++) begin
      idle_lvl <= s[0];
      sleep_sel <= s[0];
      pd_en <= 1'h1;
      HOST.pins(1'h0, ~s[0], 1'h1);
      step(PD_N + 6);
      check(state, model(0, 0, s));
      HOST.pins(1'h0, s[0], 1'h1);
      step(2);
      check(state, model(0, 0, s));
      step(PD_N + 6);
      check(state, model(0, 1, s));
      if (s == 1) check(clk_out, 8'h00);
      check(dev_sl, s);
      check(dev_sb, 1 - s);
      HOST.pins(1'h0, ~s[0], 1'h1);
      step(6);
      check(state, model(0, 0, s));
    end
    pd_en <= 1'h0;
    ls_en <= 1'h1;
    step(12);
    check(dl_sb, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      arr_in <= rnd[7:0] ^ arr_in ^ 8'h01;
      step(1);
    end
    check(gl_sb, 8'h00);
    HOST.pins(1'h0, 1'h0, 1'h0);
    step(8);
    check(cfg_rst_n, 8'h00);
    check(rst_out_n, 8'h00);
    check(state, 8'h02);
    rst_out_en <= 1'h0;
    step(1);
    check(rst_out_n, 8'h01);
    HOST.pins(1'h0, 1'h0, 1'h1);
    step(8);
    check(cfg_rst_n, 8'h01);
    check(state, model(0, 0, 0));
    summarize();
  end
endmodule : power_and_reset_control_tb
